// file: nprc_defs.svh
/*
  register offsets, field positions, reset values and timing counts
  for the protocol and bit-rate configuration bank. assumes inclusion by bare name.
*/
`ifndef NPRC_DEFS_SVH
`define NPRC_DEFS_SVH

`define NPRC_ADDR_W 8
`define NPRC_MODE_ADDR 8'h03
`define NPRC_RATE_ADDR 8'h04
`define NPRC_TYPEA_ADDR 8'h05

`define NPRC_MODE_RST 8'h08
`define NPRC_RATE_RST 8'h00
`define NPRC_TYPEA_RST 8'h00

`define NPRC_ROLE_BIT 7
`define NPRC_OM_HI 6
`define NPRC_OM_LO 3
`define NPRC_AR_BIT 0
`define NPRC_TXR_HI 7
`define NPRC_TXR_LO 4
`define NPRC_RXR_HI 3
`define NPRC_RXR_LO 0
`define NPRC_NOTXPAR_BIT 7
`define NPRC_NORXPAR_BIT 6
`define NPRC_F0_BIT 5
`define NPRC_PLEN_HI 4
`define NPRC_PLEN_LO 1
`define NPRC_ANTCOL_BIT 0

`define NPRC_RATE_MAX 4'h6
`define NPRC_RATE_VHBR 4'h4
`define NPRC_RATE_RX_TOP 4'h5
`define NPRC_START_BYTE 8'hF0

`define NPRC_PW_BASE_128 6'h23
`define NPRC_PW_BASE_64 6'h12
`define NPRC_PW_BASE_32 6'h09
`define NPRC_PW_BASE_16 6'h05
`define NPRC_PW_64_CODE5 7'h15
`define NPRC_PW_64_CODE6 7'h14

`endif

// file: nprc_pkg.sv
/*
  types for the protocol and bit-rate configuration bank.
  assumes nothing beyond a systemverilog compiler.
*/
package nprc_pkg;

  typedef enum logic [3:0] {
    NPRC_UNUSED = 4'h0,
    NPRC_PEER_ACTIVE = 4'h1,
    NPRC_TYPE_A = 4'h3,
    NPRC_TYPE_B = 4'h2,
    NPRC_TYPE_F = 4'h6,
    NPRC_TYPE1_TAG = 4'h7,
    NPRC_SUBC_STREAM = 4'h5,
    NPRC_BPSK_STREAM = 4'h4,
    NPRC_TGT_DETECT = 4'hC,
    NPRC_TGT_NORMAL = 4'hD
  } nprc_mode_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rate;
    logic [7:0] typea;
  } nprc_regs_type;

  typedef struct packed {
    nprc_mode_type op_mode;
    logic txrx_enable;
    logic [3:0] transmit_speed_code;
    logic [3:0] receive_speed_code;
    logic no_tx_parity;
    logic raw_receive;
    logic transport_frame_format;
    logic [5:0] pulse_width;
    logic pulse_width_valid;
    logic anticollision_frame;
  } nprc_frame_cfg_type;

endpackage

// file: nprc_config.sv
/*
  protocol, role, bit-rate and type-a framing configuration registers with decode.
  assumes a one-cycle strobe register port on clk, command pulses and frame
  start/end from same-clock framing logic, and an asynchronous field detector level.
*/
// Operation
// - bit 7 role; mode bits decode per role
// - initiator mode codes select seven protocols
// - target codes 0000 detect, 0001 normal
// - unsupported mode disables transmit and receive
// - defaults at reset and set-default command
// - auto collision avoidance on field off
// - upper nibble tx rate, lower rx
// - rate codes 0..6 give fc/128..fc/2
// - very-high tx rates only with type B
// - very-high rx only fc/8 and fc/4
// - unsupported rate disables transmit and receive
// - go-normal command loads rate register
// - no tx parity; host uses no-crc transmit
// - raw receive skips parity and crc
// - transport frame adds and strips F0
// - pulse width code in carrier periods
`timescale 1ns/10ps
`include "nprc_defs.svh"

module nprc_config (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`NPRC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic set_default_cmd,
  input wire logic go_normal_peer_cmd,
  input wire logic [7:0] go_normal_rate,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic ext_field_on,
  output logic frame_active,
  output nprc_pkg::nprc_frame_cfg_type frame_cfg,
  output logic live_txrx_enable,
  output logic auto_response_collision_avoid,
  output logic [7:0] start_byte
);
  import nprc_pkg::*;

  nprc_regs_type regs_r;
  nprc_frame_cfg_type live_cfg;
  nprc_frame_cfg_type frame_cfg_r;
  logic frame_active_r;
  logic [7:0] reg_rdata_r;
  logic [2:0] field_sync_r;
  logic field_on_r;
  logic rfca_r;
  logic role_target;
  logic [3:0] om_code;
  logic mode_ok;
  logic rate_ok;
  logic [3:0] tx_code;
  logic [3:0] rx_code;
  logic [6:0] pw_ext;
  logic pw_ok;
  nprc_mode_type op_mode_dec;

  assign start_byte = `NPRC_START_BYTE;

  // mode, rate and type-a registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regs_r.mode <= `NPRC_MODE_RST;
      regs_r.rate <= `NPRC_RATE_RST;
      regs_r.typea <= `NPRC_TYPEA_RST;
    end
    else if (set_default_cmd)
    begin
      regs_r.mode <= `NPRC_MODE_RST;
      regs_r.rate <= `NPRC_RATE_RST;
      regs_r.typea <= `NPRC_TYPEA_RST;
    end
    else
    begin
      if (reg_wr && reg_addr == `NPRC_MODE_ADDR)
      begin
        regs_r.mode <= reg_wdata;
      end
      if (reg_wr && reg_addr == `NPRC_TYPEA_ADDR)
      begin
        regs_r.typea <= reg_wdata;
      end
      if (go_normal_peer_cmd)
      begin
        regs_r.rate <= go_normal_rate;
      end
      else if (reg_wr && reg_addr == `NPRC_RATE_ADDR)
      begin
        regs_r.rate <= reg_wdata;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_r <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `NPRC_MODE_ADDR: reg_rdata_r <= regs_r.mode;
        `NPRC_RATE_ADDR: reg_rdata_r <= regs_r.rate;
        `NPRC_TYPEA_ADDR: reg_rdata_r <= regs_r.typea;
        default: reg_rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_r;

  assign role_target = regs_r.mode[`NPRC_ROLE_BIT];
  assign om_code = regs_r.mode[`NPRC_OM_HI:`NPRC_OM_LO];
  assign tx_code = regs_r.rate[`NPRC_TXR_HI:`NPRC_TXR_LO];
  assign rx_code = regs_r.rate[`NPRC_RXR_HI:`NPRC_RXR_LO];

  // pulse width: base plus signed code, per rate; fixed values for codes 5 and 6 at fc/64
  always_comb
  begin
    pw_ext = 7'h00;
    pw_ok = 1'b0;
    case (tx_code)
      4'h0:
      begin
        pw_ext = 7'({1'b0, `NPRC_PW_BASE_128} + {{3{regs_r.typea[`NPRC_PLEN_HI]}},
                 regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO]});
        pw_ok = 1'b1;
      end
      4'h1:
      begin
        pw_ext = 7'({1'b0, `NPRC_PW_BASE_64} + {{3{regs_r.typea[`NPRC_PLEN_HI]}},
                 regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO]});
        pw_ok = !(regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] inside {4'h7, 4'h8, 4'h9});
        if (regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] == 4'h5)
        begin
          pw_ext = `NPRC_PW_64_CODE5;
        end
        if (regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] == 4'h6)
        begin
          pw_ext = `NPRC_PW_64_CODE6;
        end
      end
      4'h2:
      begin
        pw_ext = 7'({1'b0, `NPRC_PW_BASE_32} + {{3{regs_r.typea[`NPRC_PLEN_HI]}},
                 regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO]});
        pw_ok = (regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] inside {[4'h0:4'h4], [4'hC:4'hF]});
      end
      4'h3:
      begin
        pw_ext = 7'({1'b0, `NPRC_PW_BASE_16} + {{3{regs_r.typea[`NPRC_PLEN_HI]}},
                 regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO]});
        pw_ok = (regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] inside {[4'h0:4'h3], [4'hD:4'hF]});
      end
      default:
      begin
        pw_ext = 7'h00;
        pw_ok = 1'b0;
      end
    endcase
    if (!pw_ok)
    begin
      pw_ext = 7'h00;
    end
  end

  // role and operating-mode decode
  always_comb
  begin
    op_mode_dec = NPRC_UNUSED;
    if (role_target)
    begin
      case (om_code)
        4'h0: op_mode_dec = NPRC_TGT_DETECT;
        4'h1: op_mode_dec = NPRC_TGT_NORMAL;
        default: op_mode_dec = NPRC_UNUSED;
      endcase
    end
    else
    begin
      case (om_code)
        4'h0: op_mode_dec = NPRC_PEER_ACTIVE;
        4'h1: op_mode_dec = NPRC_TYPE_A;
        4'h2: op_mode_dec = NPRC_TYPE_B;
        4'h3: op_mode_dec = NPRC_TYPE_F;
        4'h4: op_mode_dec = NPRC_TYPE1_TAG;
        4'hE: op_mode_dec = NPRC_SUBC_STREAM;
        4'hF: op_mode_dec = NPRC_BPSK_STREAM;
        default: op_mode_dec = NPRC_UNUSED;
      endcase
    end
  end

  // live decode of the current settings
  always_comb
  begin
    live_cfg = '0;
    live_cfg.op_mode = op_mode_dec;
    live_cfg.transmit_speed_code = tx_code;
    live_cfg.receive_speed_code = rx_code;
    live_cfg.txrx_enable = mode_ok && rate_ok;
    live_cfg.no_tx_parity = regs_r.typea[`NPRC_NOTXPAR_BIT];
    live_cfg.raw_receive = regs_r.typea[`NPRC_NORXPAR_BIT];
    // transport frame only in peer modes
    live_cfg.transport_frame_format = regs_r.typea[`NPRC_F0_BIT] &&
      (op_mode_dec inside {NPRC_PEER_ACTIVE, NPRC_TGT_DETECT, NPRC_TGT_NORMAL});
    live_cfg.pulse_width = pw_ext[5:0];
    live_cfg.pulse_width_valid = pw_ok;
    live_cfg.anticollision_frame = regs_r.typea[`NPRC_ANTCOL_BIT];
  end

  assign mode_ok = (op_mode_dec != NPRC_UNUSED);
  assign rate_ok = (tx_code <= `NPRC_RATE_MAX) && (rx_code <= `NPRC_RATE_RX_TOP) &&
    ((tx_code < `NPRC_RATE_VHBR) || (op_mode_dec == NPRC_TYPE_B));
  assign live_txrx_enable = live_cfg.txrx_enable;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_active_r <= 1'b0;
      frame_cfg_r <= '0;
    end
    else if (frame_start && !frame_active_r)
    begin
      frame_active_r <= 1'b1;
      frame_cfg_r <= live_cfg;
    end
    else if (frame_end)
    begin
      frame_active_r <= 1'b0;
    end
  end
  assign frame_active = frame_active_r;
  assign frame_cfg = frame_cfg_r;

  // field detector synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      field_sync_r <= 3'b000;
      field_on_r <= 1'b0;
    end
    else
    begin
      field_sync_r <= {field_sync_r[1:0], ext_field_on};
      if (field_sync_r[1] == field_sync_r[2])
      begin
        field_on_r <= field_sync_r[2];
      end
    end
  end

  // auto response start on field off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rfca_r <= 1'b0;
    end
    else
    begin
      rfca_r <= regs_r.mode[`NPRC_AR_BIT] && field_on_r && (field_sync_r[1] == field_sync_r[2])
        && !field_sync_r[2];
    end
  end
  assign auto_response_collision_avoid = rfca_r;

  // checks
  a_default_load: assert property (@(posedge clk) disable iff (!rstn)
    set_default_cmd |=> (regs_r.mode == `NPRC_MODE_RST && regs_r.rate == `NPRC_RATE_RST
      && regs_r.typea == `NPRC_TYPEA_RST))
    else $error("set-default did not restore defaults");
  a_go_normal_load: assert property (@(posedge clk) disable iff (!rstn)
    (go_normal_peer_cmd && !set_default_cmd) |=> regs_r.rate == $past(go_normal_rate))
    else $error("go-normal did not load rate");
  a_read_data: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == `NPRC_RATE_ADDR) |=> reg_rdata == $past(regs_r.rate))
    else $error("rate read mismatch");
  a_mode_gate: assert property (@(posedge clk) disable iff (!rstn)
    (role_target && om_code > 4'h1) |-> !live_txrx_enable)
    else $error("unsupported target mode left enabled");
  a_init_decode: assert property (@(posedge clk) disable iff (!rstn)
    (!role_target && om_code == 4'h2) |-> live_cfg.op_mode == NPRC_TYPE_B)
    else $error("initiator type b decode wrong");
  a_vhbr_gate: assert property (@(posedge clk) disable iff (!rstn)
    (tx_code >= `NPRC_RATE_VHBR && live_cfg.op_mode != NPRC_TYPE_B) |-> !live_txrx_enable)
    else $error("very-high tx rate outside type b");
  a_rx_rate_gate: assert property (@(posedge clk) disable iff (!rstn)
    (rx_code == 4'h6) |-> !live_txrx_enable)
    else $error("fc/2 receive left enabled");
  a_pulse_width: assert property (@(posedge clk) disable iff (!rstn)
    (tx_code == 4'h0 && regs_r.typea[`NPRC_PLEN_HI:`NPRC_PLEN_LO] == 4'h8) |-> live_cfg.pulse_width == 6'h1B)
    else $error("pulse width code 1000 not 27");
  a_frame_hold: assert property (@(posedge clk) disable iff (!rstn)
    (frame_active_r && !frame_end) |=> frame_active_r && $stable(frame_cfg_r))
    else $error("frame settings changed mid frame");
  a_auto_resp: assert property (@(posedge clk) disable iff (!rstn)
    auto_response_collision_avoid |-> ($past(regs_r.mode[`NPRC_AR_BIT]) && $past(field_on_r) && !field_on_r))
    else $error("auto response without enable and field off");
  a_target_decode: assert property (@(posedge clk) disable iff (!rstn)
    (role_target && om_code == 4'h1) |-> live_cfg.op_mode == NPRC_TGT_NORMAL)
    else $error("target normal decode wrong");
  a_rate_top: assert property (@(posedge clk) disable iff (!rstn)
    (tx_code > 4'h6 || rx_code > 4'h5) |-> !live_txrx_enable)
    else $error("unused rate code left enabled");
  a_frame_snap: assert property (@(posedge clk) disable iff (!rstn)
    (frame_start && !frame_active_r) |=> (frame_active_r && frame_cfg_r == $past(live_cfg)))
    else $error("frame settings not captured at start");
  a_transport_peer: assert property (@(posedge clk) disable iff (!rstn)
    (regs_r.typea[`NPRC_F0_BIT] && !role_target && om_code == 4'h0) |-> live_cfg.transport_frame_format)
    else $error("transport frame flag missing in peer mode");

endmodule

// file: nprc_config_bench.sv
/* self-checking bench for nprc_config: register port, decode, gating, frames.
   assumes the bank alone on one 10 MHz clock, driven by the bench. */
`timescale 1ns/10ps
module nprc_config_bench;
  import nprc_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, set_default_cmd, go_normal_peer_cmd;
  logic frame_start, frame_end, ext_field_on, frame_active, live_txrx_enable;
  logic auto_response_collision_avoid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, go_normal_rate, start_byte;
  nprc_frame_cfg_type frame_cfg;
  int err_total, n_compared, k;
  logic [16:0] rtab [12] = '{{8'h08, 8'h33, 1'h1}, {8'h08, 8'h40, 1'h0}, {8'h08, 8'h04, 1'h1},
    {8'h08, 8'h05, 1'h1}, {8'h08, 8'h06, 1'h0}, {8'h08, 8'h70, 1'h0}, {8'h10, 8'h40, 1'h1},
    {8'h10, 8'h60, 1'h1}, {8'h10, 8'h55, 1'h1}, {8'h10, 8'h06, 1'h0}, {8'h10, 8'h07, 1'h0},
    {8'h10, 8'hF0, 1'h0}};
  logic [18:0] ptab [9] = '{{8'h00, 4'h7, 6'h2A, 1'h1}, {8'h00, 4'h0, 6'h23, 1'h1},
    {8'h00, 4'h8, 6'h1B, 1'h1}, {8'h00, 4'h9, 6'h1C, 1'h1}, {8'h11, 4'h6, 6'h14, 1'h1},
    {8'h11, 4'h7, 6'h00, 1'h0}, {8'h22, 4'h4, 6'h0D, 1'h1}, {8'h33, 4'h3, 6'h08, 1'h1},
    {8'h33, 4'hC, 6'h00, 1'h0}};

  nprc_config uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .set_default_cmd(set_default_cmd),
    .go_normal_peer_cmd(go_normal_peer_cmd), .go_normal_rate(go_normal_rate),
    .frame_start(frame_start), .frame_end(frame_end), .ext_field_on(ext_field_on),
    .frame_active(frame_active), .frame_cfg(frame_cfg), .live_txrx_enable(live_txrx_enable),
    .auto_response_collision_avoid(auto_response_collision_avoid), .start_byte(start_byte));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(negedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask

  task frm;
    @(posedge clk);
    frame_start <= 1'h1;
    @(posedge clk);
    frame_start <= 1'h0;
    frame_end <= 1'h1;
    @(posedge clk);
    frame_end <= 1'h0;
    @(negedge clk);
  endtask

  task field_off(input logic [7:0] m, input logic [7:0] e);
    wr(8'h03, m);
    @(posedge clk);
    ext_field_on <= 1'h1;
    repeat (8) @(posedge clk);
    ext_field_on <= 1'h0;
    k = 0;
    repeat (10)
    begin
      @(negedge clk);
      if (auto_response_collision_avoid === 1'h1)
        k++;
    end
    chk(8'(k), e);
  endtask

  function automatic nprc_mode_type emode(input logic r, input logic [3:0] c);
    if (r)
      return (c == 4'h0) ? NPRC_TGT_DETECT : (c == 4'h1) ? NPRC_TGT_NORMAL : NPRC_UNUSED;
    case (c)
      4'h0: return NPRC_PEER_ACTIVE;
      4'h1: return NPRC_TYPE_A;
      4'h2: return NPRC_TYPE_B;
      4'h3: return NPRC_TYPE_F;
      4'h4: return NPRC_TYPE1_TAG;
      4'hE: return NPRC_SUBC_STREAM;
      4'hF: return NPRC_BPSK_STREAM;
      default: return NPRC_UNUSED;
    endcase
  endfunction

  initial
  begin
    #500000;
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    {rstn, reg_wr, reg_rd, set_default_cmd, go_normal_peer_cmd} = 5'h00;
    {frame_start, frame_end, ext_field_on} = 3'h0;
    {reg_addr, reg_wdata, go_normal_rate} = 24'h000000;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rd(8'h03, 8'h08);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h03, 8'h08);
    $display("test defaults done");
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 16; c++)
      begin
        wr(8'h03, {r[0], c[3:0], 3'h0});
        chk(8'(live_txrx_enable), 8'(emode(r[0], c[3:0]) != NPRC_UNUSED));
        frm;
        chk(8'(frame_cfg.op_mode), 8'(emode(r[0], c[3:0])));
      end
    $display("test mode decode done");
    foreach (rtab[i])
    begin
      wr(8'h03, rtab[i][16:9]);
      wr(8'h04, rtab[i][8:1]);
      chk(8'(live_txrx_enable), 8'(rtab[i][0]));
      frm;
      chk(8'(frame_cfg.txrx_enable), 8'(rtab[i][0]));
      chk({frame_cfg.transmit_speed_code, frame_cfg.receive_speed_code}, rtab[i][8:1]);
    end
    $display("test rate gating done");
    wr(8'h03, 8'h08);
    foreach (ptab[i])
    begin
      wr(8'h04, ptab[i][18:11]);
      wr(8'h05, {3'h0, ptab[i][10:7], 1'h0});
      frm;
      chk({1'h0, frame_cfg.pulse_width_valid, frame_cfg.pulse_width}, {1'h0, ptab[i][0], ptab[i][6:1]});
    end
    $display("test pulse width done");
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'hE1);
    @(posedge clk);
    frame_start <= 1'h1;
    @(posedge clk);
    frame_start <= 1'h0;
    wr(8'h05, 8'h00);
    frm;
    chk(8'(frame_active), 8'h00);
    chk({4'h0, frame_cfg.no_tx_parity, frame_cfg.raw_receive, frame_cfg.transport_frame_format,
      frame_cfg.anticollision_frame}, 8'h0F);
    chk(start_byte, 8'hF0);
    frm;
    chk(8'(frame_cfg.no_tx_parity), 8'h00);
    wr(8'h05, 8'h20);
    wr(8'h03, 8'h08);
    frm;
    chk(8'(frame_cfg.transport_frame_format), 8'h00);
    wr(8'h03, 8'h88);
    frm;
    chk(8'(frame_cfg.transport_frame_format), 8'h01);
    $display("test frame snapshot done");
    @(posedge clk);
    go_normal_rate <= 8'h5A;
    go_normal_peer_cmd <= 1'h1;
    reg_wr <= 1'h1;
    reg_addr <= 8'h04;
    reg_wdata <= 8'h33;
    @(posedge clk);
    go_normal_peer_cmd <= 1'h0;
    reg_wr <= 1'h0;
    rd(8'h04, 8'h5A);
    wr(8'h05, 8'hFF);
    @(posedge clk);
    set_default_cmd <= 1'h1;
    reg_wr <= 1'h1;
    reg_addr <= 8'h03;
    reg_wdata <= 8'h55;
    @(posedge clk);
    set_default_cmd <= 1'h0;
    reg_wr <= 1'h0;
    rd(8'h03, 8'h08);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    $display("test commands done");
    wr(8'h03, 8'h81);
    @(posedge clk);
    frame_start <= 1'h1;
    @(posedge clk);
    frame_start <= 1'h0;
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rd(8'h03, 8'h08);
    chk(8'(frame_active), 8'h00);
    $display("test mid-run reset done");
    field_off(8'h09, 8'h01);
    field_off(8'h08, 8'h00);
    $display("test auto response done");
    finish_test;
  end
endmodule
